// ==== design/dar_pkg.sv ====
package dar_pkg;
	localparam int CLK_PERIOD_PS = 25000;
	localparam int RESULT_BITS = 14;
	localparam int DAISY_SLOT_BITS = 14;
	localparam int POWERUP_TIME_US = 70;
	localparam int POWERUP_CYCLES =
		(POWERUP_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int QUIET_TIME_NS = 50;
	localparam int QUIET_CYCLES = (QUIET_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CONV_TIME_NS = 600;
	localparam int OSC_DIV = 2;
	localparam int CONV_OSC_TICKS = (CONV_TIME_NS * 1000) / (CLK_PERIOD_PS * OSC_DIV);
	localparam int SCLK_HALF_CYCLES = 8;
	localparam int START_LOW_CYCLES = 4;
	localparam int CNT_W = 12;
	localparam logic [2:0] PIN_SYNC_RESET = 3'h7;
	localparam logic [2:0] LINE_SYNC_RESET = 3'h0;

	typedef enum logic [1:0] {
		DEV_IDLE = 2'h0,
		DEV_CONV = 2'h1,
		DEV_SHUT = 2'h2
	} dar_dev_state_e;

	typedef enum logic [2:0] {
		H_POWERUP = 3'h0,
		H_IDLE = 3'h1,
		H_START = 3'h2,
		H_CONV = 3'h3,
		H_READ = 3'h4,
		H_QUIET = 3'h5
	} dar_host_state_e;
endpackage

// ==== design/dar_link_if.sv ====
`timescale 1ns/1ps
// The data lines are carried as value plus enable; a low enable means the pin floats.
interface dar_link_if;
	logic convStartN;
	logic csN;
	logic sclk;
	logic busy;
	logic serialOutA;
	logic serialOutAEn;
	logic serialOutB;
	logic serialOutBEn;

	modport adc (
		input convStartN,
		input csN,
		input sclk,
		output busy,
		output serialOutA,
		output serialOutAEn,
		output serialOutB,
		output serialOutBEn
	);

	modport host (
		output convStartN,
		output csN,
		output sclk,
		input busy,
		input serialOutA,
		input serialOutAEn,
		input serialOutB,
		input serialOutBEn
	);
endinterface

// ==== design/dar_pair_buffer.sv ====
`timescale 1ns/1ps
// Shifting buffer: entry 0 is always the head, so the read data comes straight from a flop.
module dar_pair_buffer #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int CNTW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [CNTW-1:0] count_r;
	logic inReady_r;
	logic outValid_r;

	wire push = inValid & inReady_r;
	wire pop = outValid_r & outReady;
	wire [CNTW-1:0] wrIdx = count_r - CNTW'(pop);
	wire [CNTW-1:0] countNxt = count_r + CNTW'(push) - CNTW'(pop);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count_r <= '0;
			inReady_r <= 1'b1;
			outValid_r <= 1'b0;
		end else begin
			count_r <= countNxt;
			inReady_r <= countNxt != CNTW'(DEPTH);
			outValid_r <= countNxt != '0;
		end
	end

	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		wire [WIDTH-1:0] above;
		if (i < DEPTH - 1) begin : g_mid
			assign above = mem_r[i+1];
		end else begin : g_top
			assign above = mem_r[i];
		end
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				mem_r[i] <= '0;
			end else if (push && wrIdx == CNTW'(i)) begin
				mem_r[i] <= inData;
			end else if (pop) begin
				mem_r[i] <= above;
			end
		end
	end

	assign inReady = inReady_r;
	assign outValid = outValid_r;
	assign outData = mem_r[0];
endmodule

// ==== design/dar_host_end.sv ====
`timescale 1ns/1ps
// Host end: makes the conversion start, chip select and serial clock, collects results.
module dar_host_end #(
	parameter int RESULT_BITS = dar_pkg::RESULT_BITS,
	parameter int BUF_DEPTH = 2
) (
	input wire logic clk,
	input wire logic reset,
	dar_link_if.host link,
	input wire logic startReq,
	input wire logic dualOnLineA,
	input wire logic shutdownAfter,
	output logic startReady,
	output logic [2*RESULT_BITS-1:0] wordData,
	output logic wordValid,
	input wire logic wordReady
);
	localparam int CW = dar_pkg::CNT_W;
	localparam int STREAM = RESULT_BITS + dar_pkg::DAISY_SLOT_BITS;
	localparam int WW = 2 * RESULT_BITS;

	dar_pkg::dar_host_state_e state_r;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] bitCnt_r;
	logic [2:0] lineS1_r;
	logic [2:0] lineS2_r;
	logic convN_r, csN_r, sclk_r, dual_r, shdn_r, needPwr_r, startReady_r, push_r;
	logic [STREAM-1:0] shA_r;
	logic [RESULT_BITS-1:0] shB_r;
	logic [WW-1:0] word_r;
	logic bufInReady;

	// ==========================================================
	// Pin sampling and decode
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lineS1_r <= dar_pkg::LINE_SYNC_RESET;
			lineS2_r <= dar_pkg::LINE_SYNC_RESET;
		end else begin
			lineS1_r <= {link.busy, link.serialOutA, link.serialOutB};
			lineS2_r <= lineS1_r;
		end
	end

	wire busyS = lineS2_r[2];
	wire accept = startReq & startReady_r;
	wire halfTick = cnt_r == CW'(dar_pkg::SCLK_HALF_CYCLES - 1);
	wire [CW-1:0] nBits = dual_r ? CW'(STREAM) : CW'(RESULT_BITS);
	wire endRead = halfTick & ~sclk_r & (bitCnt_r == nBits);
	wire [WW-1:0] wordNxt = dual_r ? {shA_r[STREAM-1 -: RESULT_BITS], shA_r[RESULT_BITS-1:0]}
		: {shA_r[RESULT_BITS-1:0], shB_r};

	// ==========================================================
	// Sequence
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= dar_pkg::H_POWERUP;
			cnt_r <= '0;
			bitCnt_r <= '0;
			convN_r <= 1'b1;
			csN_r <= 1'b1;
			sclk_r <= 1'b1;
			dual_r <= 1'b0;
			shdn_r <= 1'b0;
			needPwr_r <= 1'b0;
			push_r <= 1'b0;
			shA_r <= '0;
			shB_r <= '0;
			word_r <= '0;
		end else begin
			push_r <= 1'b0;
			case (state_r)
				dar_pkg::H_POWERUP: begin
					convN_r <= 1'b1;
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == CW'(dar_pkg::POWERUP_CYCLES - 1)) begin
						cnt_r <= '0;
						needPwr_r <= 1'b0;
						state_r <= needPwr_r ? dar_pkg::H_START : dar_pkg::H_IDLE;
						convN_r <= ~needPwr_r;
					end
				end
				dar_pkg::H_IDLE: begin
					if (accept) begin
						dual_r <= dualOnLineA;
						shdn_r <= shutdownAfter;
						cnt_r <= '0;
						state_r <= needPwr_r ? dar_pkg::H_POWERUP : dar_pkg::H_START;
						convN_r <= needPwr_r;
					end
				end
				dar_pkg::H_START: begin
					if (cnt_r != CW'(dar_pkg::START_LOW_CYCLES - 1)) begin
						cnt_r <= cnt_r + 1'b1;
					end else if (busyS) begin
						convN_r <= ~shdn_r;
						state_r <= dar_pkg::H_CONV;
					end
				end
				dar_pkg::H_CONV: begin
					if (!busyS) begin
						needPwr_r <= shdn_r;
						csN_r <= 1'b0;
						sclk_r <= 1'b1;
						cnt_r <= '0;
						bitCnt_r <= '0;
						state_r <= dar_pkg::H_READ;
					end
				end
				dar_pkg::H_READ: begin
					cnt_r <= halfTick ? '0 : cnt_r + 1'b1;
					if (endRead) begin
						csN_r <= 1'b1;
						word_r <= wordNxt;
						push_r <= 1'b1;
						state_r <= dar_pkg::H_QUIET;
					end else if (halfTick) begin
						sclk_r <= ~sclk_r;
						if (sclk_r) begin
							bitCnt_r <= bitCnt_r + 1'b1;
							shA_r <= {shA_r[STREAM-2:0], lineS2_r[1]};
							shB_r <= {shB_r[RESULT_BITS-2:0], lineS2_r[0]};
						end
					end
				end
				dar_pkg::H_QUIET: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == CW'(dar_pkg::QUIET_CYCLES - 1)) begin
						cnt_r <= '0;
						state_r <= dar_pkg::H_IDLE;
					end
				end
				default: state_r <= dar_pkg::H_IDLE;
			endcase
		end
	end

	// A request is only taken while the buffer has room, so the later push is never refused.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			startReady_r <= 1'b0;
		end else begin
			startReady_r <= (state_r == dar_pkg::H_IDLE) & ~accept & bufInReady;
		end
	end

	dar_pair_buffer #(
		.WIDTH(WW),
		.DEPTH(BUF_DEPTH)
	) u_buffer (
		.clk(clk),
		.reset(reset),
		.inData(word_r),
		.inValid(push_r),
		.inReady(bufInReady),
		.outData(wordData),
		.outValid(wordValid),
		.outReady(wordReady)
	);

	assign startReady = startReady_r;
	assign link.convStartN = convN_r;
	assign link.csN = csN_r;
	assign link.sclk = sclk_r;
endmodule

// ==== design/dar_adc_end.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Start falling edge starts both converters together.
// - Busy high during conversion, low when done.
// - Conversion timed by internal oscillator, not sclk.
// - One serial output per converter, either usable.
// - Host supplies serial clock and chip select.
// - Chip select fall enables outputs, presents MSB.
// - Results leave MSB first, 12 or 14 bits.
// - Later bits advance on successive sclk falls.
// - Host gives at least one result length.
// - Chip select rise floats both outputs.
// - Further clocks bring other result on line.
// - 12-bit second result preceded by two zeros.
// - Sclk fall with chip select fall ignored.
// - Early chip select gives MSB at busy fall.
// - Chip select held low: never float.
// - Start low at busy fall means shutdown.
// - Start high 70 us before next conversion.
// - Quiet interval before next start fall.
module dar_adc_end #(
	parameter int RESULT_BITS = dar_pkg::RESULT_BITS
) (
	input wire logic clk,
	input wire logic reset,
	dar_link_if.adc link,
	input wire logic [RESULT_BITS-1:0] analogA,
	input wire logic [RESULT_BITS-1:0] analogB,
	output logic poweredDown,
	output logic convDone,
	output logic [RESULT_BITS-1:0] lastResultA,
	output logic [RESULT_BITS-1:0] lastResultB
);
	localparam int CW = dar_pkg::CNT_W;
	localparam int SLOT = dar_pkg::DAISY_SLOT_BITS;
	localparam int STREAM = RESULT_BITS + SLOT;

	// The second result sits right-aligned in a fixed slot, so a short result
	// is preceded by zero bits and a full-width one is not.
	function automatic logic [STREAM-1:0] buildStream(
		input logic [RESULT_BITS-1:0] first,
		input logic [RESULT_BITS-1:0] second
	);
		buildStream = {first, SLOT'(second)};
	endfunction

	dar_pkg::dar_dev_state_e state_r;
	logic [2:0] pinS1_r;
	logic [2:0] pinS2_r;
	logic [2:0] pinS3_r;
	logic [CW-1:0] oscCnt_r;
	logic [CW-1:0] convCnt_r;
	logic [CW-1:0] pwrCnt_r;
	logic busy_r;
	logic down_r;
	logic done_r;
	logic outEn_r;
	logic [RESULT_BITS-1:0] pendA_r;
	logic [RESULT_BITS-1:0] pendB_r;
	logic [RESULT_BITS-1:0] resA_r;
	logic [RESULT_BITS-1:0] resB_r;
	logic [STREAM-1:0] shA_r;
	logic [STREAM-1:0] shB_r;

	// ==========================================================
	// Pin sampling
	// The link clock and strobes come from the host's domain; edges are found
	// only between the second and third stage.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pinS1_r <= dar_pkg::PIN_SYNC_RESET;
			pinS2_r <= dar_pkg::PIN_SYNC_RESET;
			pinS3_r <= dar_pkg::PIN_SYNC_RESET;
		end else begin
			pinS1_r <= {link.convStartN, link.csN, link.sclk};
			pinS2_r <= pinS1_r;
			pinS3_r <= pinS2_r;
		end
	end

	wire startHigh = pinS2_r[2];
	wire startFall = pinS3_r[2] & ~pinS2_r[2];
	wire csLow = ~pinS2_r[1];
	wire csFall = pinS3_r[1] & ~pinS2_r[1];
	wire sclkFall = pinS3_r[0] & ~pinS2_r[0];

	// ==========================================================
	// Internal oscillator
	// Free running and unrelated to the serial clock, so a conversion needs
	// no host clock at all.
	wire oscTick = oscCnt_r == CW'(dar_pkg::OSC_DIV - 1);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			oscCnt_r <= '0;
		end else begin
			oscCnt_r <= oscTick ? '0 : oscCnt_r + 1'b1;
		end
	end

	// ==========================================================
	// Conversion and power control
	wire inConv = state_r == dar_pkg::DEV_CONV;
	wire convEnd = inConv & oscTick & (convCnt_r == CW'(dar_pkg::CONV_OSC_TICKS - 1));
	wire pwrEnd = pwrCnt_r == CW'(dar_pkg::POWERUP_CYCLES - 1);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= dar_pkg::DEV_IDLE;
			busy_r <= 1'b0;
			down_r <= 1'b0;
			convCnt_r <= '0;
			pwrCnt_r <= '0;
		end else begin
			case (state_r)
				dar_pkg::DEV_IDLE: begin
					if (startFall) begin
						state_r <= dar_pkg::DEV_CONV;
						busy_r <= 1'b1;
						convCnt_r <= '0;
					end
				end
				dar_pkg::DEV_CONV: begin
					if (oscTick) begin
						convCnt_r <= convCnt_r + 1'b1;
					end
					if (convEnd) begin
						busy_r <= 1'b0;
						pwrCnt_r <= '0;
						if (!startHigh) begin
							state_r <= dar_pkg::DEV_SHUT;
							down_r <= 1'b1;
						end else begin
							state_r <= dar_pkg::DEV_IDLE;
						end
					end
				end
				dar_pkg::DEV_SHUT: begin
					// A start edge while powered down is ignored; the start pin
					// must first stay high for the full power-up time.
					if (!startHigh) begin
						pwrCnt_r <= '0;
					end else if (pwrEnd) begin
						state_r <= dar_pkg::DEV_IDLE;
						down_r <= 1'b0;
					end else begin
						pwrCnt_r <= pwrCnt_r + 1'b1;
					end
				end
				default: state_r <= dar_pkg::DEV_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Sampling and result store
	// Both inputs are caught in the same cycle, so the two channels are truly
	// simultaneous; the published results change only at completion.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pendA_r <= '0;
			pendB_r <= '0;
			resA_r <= '0;
			resB_r <= '0;
			done_r <= 1'b0;
		end else begin
			done_r <= convEnd;
			if (state_r == dar_pkg::DEV_IDLE && startFall) begin
				pendA_r <= analogA;
				pendB_r <= analogB;
			end
			if (convEnd) begin
				resA_r <= pendA_r;
				resB_r <= pendB_r;
			end
		end
	end

	// ==========================================================
	// Serial output path
	// Completion reloads the streams so that a chip select held low, or
	// lowered early, shows the new MSB as busy falls. A chip select fall
	// reloads too, which makes every read start from the MSB and return the
	// same held result. The load has priority over a coincident clock fall.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shA_r <= '0;
			shB_r <= '0;
			outEn_r <= 1'b0;
		end else begin
			outEn_r <= csLow;
			if (convEnd) begin
				shA_r <= buildStream(pendA_r, pendB_r);
				shB_r <= buildStream(pendB_r, pendA_r);
			end else if (csFall) begin
				shA_r <= buildStream(resA_r, resB_r);
				shB_r <= buildStream(resB_r, resA_r);
			end else if (sclkFall && csLow) begin
				shA_r <= {shA_r[STREAM-2:0], 1'b0};
				shB_r <= {shB_r[STREAM-2:0], 1'b0};
			end
		end
	end

	// Past the second result the line keeps shifting zeros; it floats only
	// when chip select rises, never on a bit count.
	assign link.busy = busy_r;
	assign link.serialOutA = shA_r[STREAM-1];
	assign link.serialOutB = shB_r[STREAM-1];
	assign link.serialOutAEn = outEn_r;
	assign link.serialOutBEn = outEn_r;
	assign poweredDown = down_r;
	assign convDone = done_r;
	assign lastResultA = resA_r;
	assign lastResultB = resB_r;
endmodule

// ==== verif/dar_link_monitor.sv ====
`timescale 1ns/1ps
module dar_link_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic convStartN,
	input wire logic csN,
	input wire logic sclk,
	input wire logic busy,
	input wire logic serialOutA,
	input wire logic serialOutAEn,
	input wire logic serialOutB,
	input wire logic serialOutBEn
);
	// ==========
	// Helper state
	// The shutdown flag keeps the start check quiet until the power-up span has run.
	logic [11:0] highCnt_r;
	logic [11:0] highCnt_nxt;
	logic [5:0] falls_r;
	logic [5:0] falls_nxt;
	logic shut_r;
	logic shut_nxt;
	logic sclkD_r;
	logic busyD_r;
	wire sclkFell = sclkD_r && !sclk;
	assign highCnt_nxt = !convStartN ? 12'h0 : highCnt_r + {11'h0, highCnt_r != 12'hfff};
	assign falls_nxt = csN ? 6'h0 : falls_r + {5'h0, sclkFell && falls_r != 6'h3f};
	assign shut_nxt = (busyD_r && !busy && !convStartN) ? 1'b1 :
		(highCnt_r >= 12'haef) ? 1'b0 : shut_r;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{highCnt_r, falls_r, shut_r, sclkD_r, busyD_r} <= {12'h0, 6'h0, 3'h2};
		end else begin
			{highCnt_r, falls_r, shut_r, sclkD_r, busyD_r} <= {highCnt_nxt, falls_nxt, shut_nxt, sclk, busy};
		end
	end
	// ==========
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	busy_start_a: assert property ($fell(convStartN) && !busy && !shut_r |-> ##[2:4] busy)
		else $error("busy missing after start");
	busy_cause_a: assert property ($rose(busy) |-> !$past(convStartN, 3) && $past(convStartN, 4))
		else $error("busy rose without start");
	busy_len_a: assert property ($rose(busy) |-> (busy[*8] ##1 busy[*8] ##1 busy[*6]) ##[1:4] !busy)
		else $error("busy length wrong");
	drive_on_cs_a: assert property ($fell(csN) |-> ##3 serialOutAEn && serialOutBEn)
		else $error("outputs not driven after select");
	float_on_cs_a: assert property ($rose(csN) |-> ##3 !serialOutAEn && !serialOutBEn)
		else $error("outputs driven after deselect");
	float_idle_a: assert property (csN && $past(csN, 3) |-> !serialOutAEn && !serialOutBEn)
		else $error("outputs driven while deselected");
	shift_line_a: assert property (serialOutAEn && $past(serialOutAEn) && $changed(serialOutA)
		|-> $past(sclkFell, 3))
		else $error("line a changed without clock fall");
	shift_line_b_a: assert property (serialOutBEn && $past(serialOutBEn) && $changed(serialOutB)
		|-> $past(sclkFell, 3))
		else $error("line b changed without clock fall");
	sclk_framed_a: assert property (sclkFell |-> !csN)
		else $error("serial clock fell outside a frame");
	read_len_a: assert property ($rose(csN) |-> falls_r >= 6'd14)
		else $error("frame too short");
	cover property ($rose(csN) && falls_r == 6'd14);
	cover property ($rose(csN) && falls_r == 6'd28);
	cover property ($fell(busy) && !convStartN);
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [13:0] analogA = 14'h0;
	logic [13:0] analogB = 14'h0;
	logic startReq = 1'b0;
	logic dualOnLineA = 1'b0;
	logic shutdownAfter = 1'b0;
	logic wordReady = 1'b0;
	logic poweredDown;
	logic convDone;
	logic startReady;
	logic wordValid;
	logic [13:0] lastResultA;
	logic [13:0] lastResultB;
	logic [27:0] wordData;
	logic [27:0] lineA = 28'h0;
	logic [27:0] lineB = 28'h0;
	int miscompares = 0;
	int total_checks = 0;
	int doneCnt = 0;
	dar_link_if link ();
	dar_adc_end dar_adc_end_i (.clk(clk), .reset(reset), .link(link.adc), .analogA(analogA),
		.analogB(analogB), .poweredDown(poweredDown), .convDone(convDone),
		.lastResultA(lastResultA), .lastResultB(lastResultB));
	dar_host_end dar_host_end_i (.clk(clk), .reset(reset), .link(link.host), .startReq(startReq),
		.dualOnLineA(dualOnLineA), .shutdownAfter(shutdownAfter), .startReady(startReady),
		.wordData(wordData), .wordValid(wordValid), .wordReady(wordReady));
	dar_link_monitor dar_link_monitor_i (.clk(clk), .reset(reset), .convStartN(link.convStartN),
		.csN(link.csN), .sclk(link.sclk), .busy(link.busy), .serialOutA(link.serialOutA),
		.serialOutAEn(link.serialOutAEn), .serialOutB(link.serialOutB),
		.serialOutBEn(link.serialOutBEn));
	// ==========
	// Short-result pair
	// Only a 12-bit pair shows the two zero bits ahead of the second result on a shared line.
	logic start12 = 1'b0;
	logic ready12;
	logic valid12;
	logic [23:0] word12;
	logic [25:0] line12 = 26'h0;
	dar_link_if link12 ();
	dar_adc_end #(.RESULT_BITS(12)) dar_adc_end_12_i (.clk(clk), .reset(reset),
		.link(link12.adc), .analogA(12'hc35), .analogB(12'h9a7), .poweredDown(),
		.convDone(), .lastResultA(), .lastResultB());
	dar_host_end #(.RESULT_BITS(12)) dar_host_end_12_i (.clk(clk), .reset(reset),
		.link(link12.host), .startReq(start12), .dualOnLineA(1'b1), .shutdownAfter(1'b0),
		.startReady(ready12), .wordData(word12), .wordValid(valid12), .wordReady(1'b1));
	always @(negedge link12.sclk) begin
		if (link12.csN === 1'b0) line12 = {line12[24:0], link12.serialOutA};
	end
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		if (convDone === 1'b1) doneCnt++;
	end
	// ==========
	// Wire sampler
	// Bits are taken at the clock fall, as the host does, before the three-cycle update lands.
	always @(negedge link.sclk) begin
		if (link.csN === 1'b0) begin
			lineA = {lineA[26:0], link.serialOutA};
			lineB = {lineB[26:0], link.serialOutB};
		end
	end
	// ==========
	// Tasks
	task check(input string what, input logic [27:0] seen, input logic [27:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task start(input logic [13:0] a, input logic [13:0] b, input logic dual, input logic shut);
		for (int i = 0; i < 4000 && startReady !== 1'b1; i++) @(negedge clk);
		check("startReady", 28'(startReady), 28'h1);
		analogA = a;
		analogB = b;
		dualOnLineA = dual;
		shutdownAfter = shut;
		startReq = 1'b1;
		@(negedge clk);
		startReq = 1'b0;
	endtask
	// The wait must cover a full power-up span after a shutdown conversion.
	task take(input logic [27:0] exp);
		for (int i = 0; i < 4000 && wordValid !== 1'b1; i++) @(negedge clk);
		check("wordValid", 28'(wordValid), 28'h1);
		check("wordData", wordData, exp);
		wordReady = 1'b1;
		@(negedge clk);
		wordReady = 1'b0;
		@(negedge clk);
	endtask
	// ==========
	// Tests
	initial begin
		repeat (12) @(negedge clk);
		reset = 1'b0;
		for (int i = 0; i < 4000 && ready12 !== 1'b1; i++) @(negedge clk);
		start12 = 1'b1;
		@(negedge clk);
		start12 = 1'b0;
		for (int i = 0; i < 2000 && valid12 !== 1'b1; i++) @(negedge clk);
		check("valid12", 28'(valid12), 28'h1);
		check("word12", 28'(word12), {4'h0, 12'hc35, 12'h9a7});
		check("line12", 28'(line12), {2'h0, 12'hc35, 2'h0, 12'h9a7});
		$display("test short pair done");
		start(14'h2a5c, 14'h15a3, 1'b0, 1'b0);
		take({14'h2a5c, 14'h15a3});
		check("lineA", 28'(lineA[13:0]), 28'h2a5c);
		check("lineB", 28'(lineB[13:0]), 28'h15a3);
		check("lastResultA", 28'(lastResultA), 28'h2a5c);
		$display("test parallel read done");
		start(14'h3fff, 14'h0001, 1'b1, 1'b0);
		take({14'h3fff, 14'h0001});
		check("lineA", lineA, {14'h3fff, 14'h0001});
		$display("test daisy read done");
		start(14'h0001, 14'h2000, 1'b0, 1'b0);
		start(14'h1234, 14'h0abc, 1'b1, 1'b0);
		repeat (700) @(negedge clk);
		check("startReady", 28'(startReady), 28'h0);
		take({14'h0001, 14'h2000});
		take({14'h1234, 14'h0abc});
		$display("test buffer stall done");
		start(14'h0f0f, 14'h30c3, 1'b0, 1'b1);
		take({14'h0f0f, 14'h30c3});
		check("poweredDown", 28'(poweredDown), 28'h1);
		check("lastResultB", 28'(lastResultB), 28'h30c3);
		start(14'h0555, 14'h3aaa, 1'b1, 1'b0);
		take({14'h0555, 14'h3aaa});
		check("poweredDown", 28'(poweredDown), 28'h0);
		check("convDone count", 28'(doneCnt), 28'h6);
		$display("test shutdown done");
		final_report();
	end
	initial begin
		#(25 * 30000);
		miscompares++;
		$display("watchdog expired");
		final_report();
	end
endmodule
